// ---- src/ecs_defines.svh ----
// Constants of the exception cause and state save unit
`ifndef ECS_DEFINES_SVH
`define ECS_DEFINES_SVH

// Cause register field positions
`define ECS_CODE_LSB       2
`define ECS_CODE_MSB       6
`define ECS_PEND_LSB       8
`define ECS_PEND_MSB       15
`define ECS_CE_LSB         28
`define ECS_CE_MSB         29
`define ECS_DS_BIT         31
`define ECS_CAUSE_RESET    32'h0000_0000

// Cause codes the hardware raises itself
`define ECS_CODE_INT       5'h00
`define ECS_CODE_TLB_MOD   5'h01
`define ECS_CODE_TLB_LOAD_INVALID      5'h02
`define ECS_CODE_TLB_STORE_INVALID      5'h03
`define ECS_CODE_ADDR_LOAD_FAULT      5'h04
`define ECS_CODE_ADDR_STORE_FAULT      5'h05
`define ECS_CODE_IBUS      5'h06
`define ECS_CODE_DBUS      5'h07
`define ECS_CODE_SYS       5'h08
`define ECS_CODE_BRK       5'h09
`define ECS_CODE_ILL       5'h0A
`define ECS_CODE_CPU       5'h0B
`define ECS_CODE_OVF       5'h0C
// Codes only the refill firmware writes into saved state
`define ECS_CODE_BAD_PT    5'h0D
`define ECS_CODE_PT_MISS   5'h0E
`define ECS_CODE_HW_MAX    5'h0C

// Handler vectors
`define ECS_VEC_BOOT       32'h1FC0_0180
`define ECS_VEC_EXEC       32'h0000_0080

// Old and new state areas in the reserved first RAM frame
`define ECS_RAM_FRAME      32'h2000_0000
`define ECS_INT_OLD        32'h2000_0000
`define ECS_INT_NEW        32'h2000_008C
`define ECS_TLB_OLD        32'h2000_0118
`define ECS_TLB_NEW        32'h2000_01A4
`define ECS_PGM_OLD        32'h2000_0230
`define ECS_PGM_NEW        32'h2000_02BC
`define ECS_SVC_OLD        32'h2000_0348
`define ECS_SVC_NEW        32'h2000_03D4

// State block layout
`define ECS_STATE_WORDS    6'd35
`define ECS_SLOT_CAUSE     6'd1
`define ECS_SLOT_PC        6'd3

// Mode and interrupt-enable stack reset (kernel, interrupts off)
`define ECS_STACK_RESET    6'h00
`define ECS_VM_RESET       3'h0

`endif

// ---- src/ecs_pkg.sv ----
// Types of the exception cause and state save unit
package ecs_pkg;

  // Exception class, selects the state areas
  typedef enum logic [1:0] {
    ECS_CLS_INT = 2'b00,
    ECS_CLS_TLB = 2'b01,
    ECS_CLS_PGM = 2'b10,
    ECS_CLS_SVC = 2'b11
  } ecs_class_t;

  // Save and restore sequencer states
  typedef enum logic [2:0] {
    ECS_ST_IDLE  = 3'b000,
    ECS_ST_FETCH = 3'b001,
    ECS_ST_STORE = 3'b010,
    ECS_ST_LOAD  = 3'b011,
    ECS_ST_DONE  = 3'b100
  } ecs_state_t;

endpackage : ecs_pkg

// ---- src/ecs_area_map.sv ----
// Maps a cause code to its class and to its old and new state areas
`timescale 1ns/1ps
`default_nettype none
`include "ecs_defines.svh"

module ecs_area_map
  import ecs_pkg::*;
(
  // Code in
  input  wire logic [4:0]  code,
  // Class and areas out
  output ecs_class_t       cls,
  output logic      [31:0] old_base,
  output logic      [31:0] new_base
);

  ////////////////////////////////////////////////////////////////////////////
  // Class decode; unknown codes fall into the program trap class
  always_comb begin
    case (code)
      `ECS_CODE_INT:                                cls = ECS_CLS_INT;
      `ECS_CODE_TLB_MOD, `ECS_CODE_TLB_LOAD_INVALID, `ECS_CODE_TLB_STORE_INVALID,
      `ECS_CODE_BAD_PT, `ECS_CODE_PT_MISS:          cls = ECS_CLS_TLB;
      `ECS_CODE_SYS, `ECS_CODE_BRK:                 cls = ECS_CLS_SVC;
      default:                                      cls = ECS_CLS_PGM;
    endcase
  end

  // Area bases per class
  always_comb begin
    case (cls)
      ECS_CLS_INT: begin
        old_base = `ECS_INT_OLD;
        new_base = `ECS_INT_NEW;
      end
      ECS_CLS_TLB: begin
        old_base = `ECS_TLB_OLD;
        new_base = `ECS_TLB_NEW;
      end
      ECS_CLS_PGM: begin
        old_base = `ECS_PGM_OLD;
        new_base = `ECS_PGM_NEW;
      end
      default: begin
        old_base = `ECS_SVC_OLD;
        new_base = `ECS_SVC_NEW;
      end
    endcase
  end

endmodule : ecs_area_map
`default_nettype wire

// ---- src/ecs_line_prio.sv ----
// Picks the pending interrupt line of highest precedence
`timescale 1ns/1ps
`default_nettype none

module ecs_line_prio #(
  parameter int LINES = 8
) (
  // Pending lines in
  input  wire logic [LINES-1:0]         pend,
  // Winner out
  output logic                          any,
  output logic [$clog2(LINES)-1:0]      line
);

  ////////////////////////////////////////////////////////////////////////////
  // Scan from the top so the lowest set line is left standing last
  always_comb begin
    any  = |pend;
    line = '0;
    for (int i = LINES - 1; i >= 0; i--) begin
      if (pend[i]) begin
        line = ($clog2(LINES))'(i);
      end
    end
  end

endmodule : ecs_line_prio
`default_nettype wire

// ---- src/ecs_cause_unit.sv ----
// Exception cause register, entry actions and state save sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ecs_defines.svh"

module ecs_cause_unit
  import ecs_pkg::*;
#(
  parameter int LINES = 8
) (
  // Clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  // Interrupt lines from devices
  input  wire logic [LINES-1:0]  IRQ_LINES,
  // Exception request from the pipeline
  input  wire logic              EXC_RAISE,
  input  wire logic [4:0]        EXC_CODE,
  input  wire logic [1:0]        EXC_CPU_NUM,
  input  wire logic              EXC_IN_DELAY,
  input  wire logic [31:0]       EXC_PC,
  input  wire logic              EXC_RETURN,
  input  wire logic              BOOT_VECTOR_SELECT,
  // Cause register access
  input  wire logic              CAUSE_WR_EN,
  input  wire logic [31:0]       CAUSE_WR_DATA,
  output logic      [31:0]       CAUSE_RD_DATA,
  // Mode and translation stacks
  input  wire logic              STACK_WR_EN,
  input  wire logic [5:0]        STACK_WR_DATA,
  input  wire logic [2:0]        VM_WR_DATA,
  output logic      [5:0]        MODE_IRQ_STACK,
  output logic      [2:0]        VM_STACK,
  // Program counter control
  output logic                   PC_LOAD,
  output logic      [31:0]       PC_VALUE,
  output logic      [31:0]       EXCEPTION_RETURN_PC,
  // State word access to the register file
  output logic      [5:0]        STATE_IDX,
  input  wire logic [31:0]       STATE_RD_DATA,
  output logic                   STATE_WR_EN,
  output logic      [31:0]       STATE_WR_DATA,
  // Memory port to the reserved frame
  output logic                   MEM_REQ,
  output logic                   MEM_WE,
  output logic      [31:0]       MEM_ADDR,
  output logic      [31:0]       MEM_WDATA,
  input  wire logic              MEM_READY,
  input  wire logic [31:0]       MEM_RDATA,
  // Status
  output logic                   SEQ_BUSY,
  output logic                   IRQ_ANY,
  output logic      [2:0]        IRQ_TOP_LINE
);

  ////////////////////////////////////////////////////////////////////////////
  // All state of the unit in one record
  typedef struct packed {
    ecs_state_t        st;        // Sequencer state
    logic [LINES-1:0]  sync1;     // First sync stage, read by sync2 only
    logic [LINES-1:0]  sync2;     // Second sync stage
    logic [1:0]        sw_pend;   // Software pending lines 0 and 1
    logic [4:0]        code;      // Cause code field
    logic [1:0]        ce;        // Coprocessor index field
    logic              ds;        // Delay slot flag
    logic [31:0]       exception_return_pc;       // Exception return PC
    logic [5:0]        mode_irq_stack;     // Mode and interrupt-enable stack
    logic [2:0]        vm;        // Translation stack
    ecs_class_t        cls;       // Class of the active exception
    logic [31:0]       old_base;  // Old area of the active class
    logic [31:0]       new_base;  // New area of the active class
    logic [5:0]        idx;       // State word index
    logic              mem_req;
    logic              mem_we;
    logic [31:0]       mem_addr;
    logic [31:0]       mem_wdata;
    logic              st_wr_en;
    logic [31:0]       st_wr_data;
    logic              pc_load;
    logic [31:0]       pc_val;
    logic [31:0]       cause_rd;
    logic              irq_any;
    logic [2:0]        irq_top;
    logic              busy;      // Sequencer active, interrupts held off
  } ecs_regs_t;

  ecs_regs_t             r_reg;      // Registered state
  ecs_regs_t             r_next;     // Next state
  logic [LINES-1:0]      pend;       // Live pending lines
  logic [4:0]            take_code;  // Code of the exception taken now
  ecs_class_t            take_cls;   // Its class
  logic [31:0]           take_old;   // Its old area
  logic [31:0]           take_new;   // Its new area
  logic                  prio_any;   // Some line pending
  logic [2:0]            prio_line;  // Lowest pending line
  logic [31:0]           cause_now;  // Assembled cause word

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Hardware and software requests merge; several lines may stand at once
  assign pend = r_reg.sync2 | {{(LINES-2){1'b0}}, r_reg.sw_pend};

  // Synchronous faults take the code given; a pure interrupt takes code 0.
  // Firmware-only codes are recoded before the class lookup, so the save
  // area always belongs to the code that is recorded
  assign take_code = !EXC_RAISE                     ? `ECS_CODE_INT :
                     (EXC_CODE > `ECS_CODE_HW_MAX) ? `ECS_CODE_ILL :
                     EXC_CODE;

  // Cause word; reserved bits read as zero
  always_comb begin
    cause_now                               = `ECS_CAUSE_RESET;
    cause_now[`ECS_PEND_MSB:`ECS_PEND_LSB]  = pend;
    cause_now[`ECS_CODE_MSB:`ECS_CODE_LSB]  = r_reg.code;
    cause_now[`ECS_CE_MSB:`ECS_CE_LSB]      = r_reg.ce;
    cause_now[`ECS_DS_BIT]                  = r_reg.ds;
  end

  // Class and area lookup for the exception being taken
  ecs_area_map u_area (
    .code     (take_code),
    .cls      (take_cls),
    .old_base (take_old),
    .new_base (take_new)
  );

  // Line precedence for status
  ecs_line_prio #(.LINES(LINES)) u_prio (
    .pend (pend),
    .any  (prio_any),
    .line (prio_line)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    r_next          = r_reg;
    r_next.sync1    = IRQ_LINES;
    r_next.sync2    = r_reg.sync1;
    r_next.pc_load  = 1'b0;
    r_next.st_wr_en = 1'b0;
    r_next.irq_any  = prio_any;
    r_next.irq_top  = prio_line;
    r_next.cause_rd = cause_now;

    // Only the two low pending bits take software writes
    if (CAUSE_WR_EN) begin
      r_next.sw_pend = CAUSE_WR_DATA[`ECS_PEND_LSB+1:`ECS_PEND_LSB];
    end

    // Software reloads the stacks when idle
    if (STACK_WR_EN && r_reg.st == ECS_ST_IDLE) begin
      r_next.mode_irq_stack = STACK_WR_DATA;
      r_next.vm    = VM_WR_DATA;
    end

    case (r_reg.st)
      // Wait for a fault or an enabled interrupt
      ECS_ST_IDLE: begin
        if (EXC_RETURN) begin
          // Pop both stacks on return
          r_next.mode_irq_stack = {r_reg.mode_irq_stack[5:4], r_reg.mode_irq_stack[5:2]};
          r_next.vm    = {r_reg.vm[2], r_reg.vm[2:1]};
        end else if (EXC_RAISE || (prio_any && r_reg.mode_irq_stack[0])) begin
          // Entry changes stacks, return PC, cause code and delay flag, and the coprocessor index on a code 11 fault only
          r_next.mode_irq_stack = {r_reg.mode_irq_stack[3:0], 2'b00};
          r_next.vm    = {r_reg.vm[1:0], 1'b0};
          r_next.exception_return_pc   = EXC_PC;
          // Codes above 12 are firmware only; hardware never raises them
          r_next.code  = (take_code > `ECS_CODE_HW_MAX) ?
                         `ECS_CODE_ILL : take_code;
          if (EXC_RAISE && EXC_CODE == `ECS_CODE_CPU) begin
            r_next.ce  = EXC_CPU_NUM;
          end
          r_next.ds       = EXC_RAISE && EXC_IN_DELAY;
          r_next.cls      = take_cls;
          r_next.old_base = take_old;
          r_next.new_base = take_new;
          // Jump to the handler vector
          r_next.pc_load  = 1'b1;
          r_next.pc_val   = BOOT_VECTOR_SELECT ? `ECS_VEC_BOOT : `ECS_VEC_EXEC;
          r_next.idx      = 6'd0;
          r_next.st       = ECS_ST_FETCH;
        end
      end

      // Present the state word index to the register file
      ECS_ST_FETCH: begin
        r_next.mem_req  = 1'b1;
        r_next.mem_we   = 1'b1;
        r_next.mem_addr = r_reg.old_base + {24'h00_0000, r_reg.idx, 2'b00};
        // Return PC and live cause replace the register file words
        if (r_reg.idx == `ECS_SLOT_PC) begin
          r_next.mem_wdata = r_reg.exception_return_pc;
        end else if (r_reg.idx == `ECS_SLOT_CAUSE) begin
          r_next.mem_wdata = cause_now;
        end else begin
          r_next.mem_wdata = STATE_RD_DATA;
        end
        r_next.st = ECS_ST_STORE;
      end

      // Store one word; all stores finish before any load
      ECS_ST_STORE: begin
        if (MEM_READY) begin
          r_next.mem_req = 1'b0;
          if (r_reg.idx == `ECS_STATE_WORDS - 6'd1) begin
            r_next.idx      = 6'd0;
            r_next.mem_req  = 1'b1;
            r_next.mem_we   = 1'b0;
            r_next.mem_addr = r_reg.new_base;
            r_next.st       = ECS_ST_LOAD;
          end else begin
            r_next.idx = r_reg.idx + 6'd1;
            r_next.st  = ECS_ST_FETCH;
          end
        end
      end

      // Load one word per ready; the PC slot steers the PC
      ECS_ST_LOAD: begin
        if (MEM_READY) begin
          r_next.st_wr_en   = 1'b1;
          r_next.st_wr_data = MEM_RDATA;
          if (r_reg.idx == `ECS_SLOT_PC) begin
            r_next.pc_load = 1'b1;
            r_next.pc_val  = MEM_RDATA;
          end
          if (r_reg.idx == `ECS_STATE_WORDS - 6'd1) begin
            r_next.mem_req = 1'b0;
            r_next.st      = ECS_ST_DONE;
          end else begin
            r_next.idx      = r_reg.idx + 6'd1;
            r_next.mem_addr = r_reg.mem_addr + 32'h0000_0004;
          end
        end
      end

      // One cycle for the last register file write to land
      ECS_ST_DONE: begin
        r_next.st = ECS_ST_IDLE;
      end

      default: begin
        r_next.st = ECS_ST_IDLE;
      end
    endcase
    // Busy is kept as a flop so the status pin is glitch free
    r_next.busy = (r_next.st != ECS_ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset values are constants only
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      r_reg            <= '0;
      r_reg.st         <= ECS_ST_IDLE;
      r_reg.mode_irq_stack      <= `ECS_STACK_RESET;
      r_reg.vm         <= `ECS_VM_RESET;
      r_reg.cause_rd   <= `ECS_CAUSE_RESET;
      r_reg.cls        <= ECS_CLS_INT;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  assign CAUSE_RD_DATA       = r_reg.cause_rd;
  assign MODE_IRQ_STACK      = r_reg.mode_irq_stack;
  assign VM_STACK            = r_reg.vm;
  assign PC_LOAD             = r_reg.pc_load;
  assign PC_VALUE            = r_reg.pc_val;
  assign EXCEPTION_RETURN_PC = r_reg.exception_return_pc;
  assign STATE_IDX           = r_reg.idx;
  assign STATE_WR_EN         = r_reg.st_wr_en;
  assign STATE_WR_DATA       = r_reg.st_wr_data;
  assign MEM_REQ             = r_reg.mem_req;
  assign MEM_WE              = r_reg.mem_we;
  assign MEM_ADDR            = r_reg.mem_addr;
  assign MEM_WDATA           = r_reg.mem_wdata;
  // Interrupts stay off while a state block moves
  assign SEQ_BUSY            = r_reg.busy;
  assign IRQ_ANY             = r_reg.irq_any;
  assign IRQ_TOP_LINE        = r_reg.irq_top;

endmodule : ecs_cause_unit
`default_nettype wire

// ---- verif/ecs_cause_unit_properties.sv ----
// Port-level assertions for the exception cause unit
`timescale 1ns/1ps
`default_nettype none
`include "ecs_defines.svh"

module ecs_cause_checker #(
  parameter int LINES = 8
) (
  // Clock and reset
  input wire logic             REF_CLK,
  input wire logic             RST,
  // Requests into the unit
  input wire logic [LINES-1:0] IRQ_LINES,
  input wire logic             EXC_RAISE,
  input wire logic [4:0]       EXC_CODE,
  input wire logic [1:0]       EXC_CPU_NUM,
  input wire logic             EXC_IN_DELAY,
  input wire logic [31:0]      EXC_PC,
  input wire logic             EXC_RETURN,
  input wire logic             STACK_WR_EN,
  input wire logic             BOOT_VECTOR_SELECT,
  // Answers of the unit
  input wire logic [31:0]      CAUSE_RD_DATA,
  input wire logic [5:0]       MODE_IRQ_STACK,
  input wire logic             PC_LOAD,
  input wire logic [31:0]      PC_VALUE,
  input wire logic [31:0]      EXCEPTION_RETURN_PC,
  input wire logic             MEM_REQ,
  input wire logic             MEM_WE,
  input wire logic [31:0]      MEM_ADDR,
  input wire logic             MEM_READY,
  input wire logic             SEQ_BUSY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  logic [LINES-1:0] irq_d1_reg, irq_d2_reg, irq_d3_reg; // Two sync stages plus read register
  logic [5:0]       stack_q_reg;                        // Stack as it stood one edge ago

  ////////////////////////////////////////////////////////////////////////////////
  // Helper history, cleared with the unit so no stale value leaks past reset
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      irq_d1_reg  <= '0;
      irq_d2_reg  <= '0;
      irq_d3_reg  <= '0;
      stack_q_reg <= 6'h00;
    end else begin
      irq_d1_reg  <= IRQ_LINES;
      irq_d2_reg  <= irq_d1_reg;
      irq_d3_reg  <= irq_d2_reg;
      stack_q_reg <= MODE_IRQ_STACK;
    end
  end

  // A synchronous exception the unit must take at this edge
  sequence s_taken;
    !SEQ_BUSY && EXC_RAISE && !EXC_RETURN && !STACK_WR_EN;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_vector_load: assert property (s_taken |-> ##[1:2] (PC_LOAD && PC_VALUE ==
    (BOOT_VECTOR_SELECT ? `ECS_VEC_BOOT : `ECS_VEC_EXEC))) else $error("handler vector wrong");
  a_return_pc: assert property (s_taken |=> EXCEPTION_RETURN_PC == $past(EXC_PC))
    else $error("return pc not captured");
  a_stack_push: assert property (s_taken |=> MODE_IRQ_STACK == {stack_q_reg[3:0], 2'b00})
    else $error("mode stack not pushed");
  a_code_record: assert property (s_taken ##0 (EXC_CODE <= 5'd12) |->
    ##2 CAUSE_RD_DATA[6:2] == $past(EXC_CODE, 2)) else $error("cause code wrong");
  a_cpu_index: assert property (s_taken ##0 (EXC_CODE == `ECS_CODE_CPU) |->
    ##2 CAUSE_RD_DATA[29:28] == $past(EXC_CPU_NUM, 2)) else $error("coprocessor index wrong");
  a_delay_flag: assert property (s_taken ##0 (EXC_CODE != 5'd0) |->
    ##2 CAUSE_RD_DATA[31] == $past(EXC_IN_DELAY, 2)) else $error("delay flag wrong");
  a_lines_track: assert property (CAUSE_RD_DATA[15:10] == irq_d3_reg[7:2])
    else $error("pending lines lag or latch");
  a_busy_masked: assert property (SEQ_BUSY |-> !MODE_IRQ_STACK[0])
    else $error("interrupts enabled during save");
  a_req_hold: assert property (MEM_REQ && !MEM_READY |=>
    MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE)) else $error("memory request dropped");
endmodule : ecs_cause_checker

bind ecs_cause_unit ecs_cause_checker #(.LINES(LINES)) i_ecs_cause_checker (
  .REF_CLK, .RST, .IRQ_LINES, .EXC_RAISE, .EXC_CODE, .EXC_CPU_NUM, .EXC_IN_DELAY,
  .EXC_PC, .EXC_RETURN, .STACK_WR_EN, .BOOT_VECTOR_SELECT, .CAUSE_RD_DATA,
  .MODE_IRQ_STACK, .PC_LOAD, .PC_VALUE, .EXCEPTION_RETURN_PC, .MEM_REQ, .MEM_WE,
  .MEM_ADDR, .MEM_READY, .SEQ_BUSY
);

`default_nettype wire

// ---- verif/ecs_frame_model.sv ----
// Behavioural model of the reserved RAM frame and the register file
`timescale 1ns/1ps
`default_nettype none

module ecs_frame_model (
  // Clock, reset and answer speed
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  // Memory port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ready,
  output logic      [31:0] mem_rdata,
  // Register file read port
  input  wire logic [5:0]  state_idx,
  output logic      [31:0] state_rd_data
);
  logic [31:0] mem [0:1023]; // One 4 KB frame, word addressed
  logic [1:0]  wait_reg;     // Cycles waited on this request
  logic [31:0] noise_reg;    // Bus is not held between answers

  // Unwritten words read as the inverted address, so areas are told apart
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = ~{20'h2_0000, i[9:0], 2'b00};
    end
  end

  // Register word i reads as a marker plus its index
  assign state_rd_data = 32'h5A00_0000 | 32'(state_idx);
  assign mem_rdata     = mem_ready ? mem[mem_addr[11:2]] : noise_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // One ready pulse per request, at once or after three extra cycles
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ready <= 1'b0;
      wait_reg  <= 2'd0;
      noise_reg <= 32'h0000_0000;
    end else begin
      noise_reg <= ~noise_reg + 32'h0000_0001;
      mem_ready <= 1'b0;
      if (mem_req && !mem_ready) begin
        if (wait_reg == (slow ? 2'd3 : 2'd0)) begin
          mem_ready <= 1'b1;
          wait_reg  <= 2'd0;
          if (mem_we) begin
            mem[mem_addr[11:2]] <= mem_wdata;
          end
        end else begin
          wait_reg <= wait_reg + 2'd1;
        end
      end
    end
  end
endmodule : ecs_frame_model

`default_nettype wire

// ---- verif/exception_cause_state_test.sv ----
// Self-checking bench of the exception cause unit
`timescale 1ns/1ps
`default_nettype none
`include "ecs_defines.svh"

module exception_cause_state_test;
  // Counters and expectations
  int          miscompares = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic [1:0]  ce_exp = 2'b00;
  logic [4:0]  code_exp;
  // Design inputs, all defined at time zero
  logic        ref_clk = 1'b0, rst = 1'b1, slow = 1'b0, exc_raise = 1'b0, exc_dly = 1'b0;
  logic        exc_ret = 1'b0, boot_sel = 1'b0, cause_we = 1'b0, stack_we = 1'b0;
  logic [7:0]  irq_lines = 8'h00;
  logic [4:0]  exc_code = 5'h00;
  logic [1:0]  exc_cpu = 2'b00;
  logic [31:0] exc_pc = 32'h0000_0000, cause_wd = 32'h0000_0000;
  logic [5:0]  stack_wd = 6'h00;
  logic [2:0]  vm_wd = 3'h0;
  // Design outputs
  logic [31:0] cause_rd, pc_value, exception_return_pc, state_rd, mem_addr, mem_wdata, mem_rdata, state_wd;
  logic [5:0]  mode_stack, state_idx;
  logic [2:0]  vm_stack, irq_top;
  logic        pc_load, state_we, mem_req, mem_we, mem_ready, seq_busy, irq_any;

  ecs_cause_unit #(.LINES(8)) i_ecs_cause_unit (
    .REF_CLK(ref_clk), .RST(rst), .IRQ_LINES(irq_lines), .EXC_RAISE(exc_raise),
    .EXC_CODE(exc_code), .EXC_CPU_NUM(exc_cpu), .EXC_IN_DELAY(exc_dly), .EXC_PC(exc_pc),
    .EXC_RETURN(exc_ret), .BOOT_VECTOR_SELECT(boot_sel), .CAUSE_WR_EN(cause_we),
    .CAUSE_WR_DATA(cause_wd), .CAUSE_RD_DATA(cause_rd), .STACK_WR_EN(stack_we),
    .STACK_WR_DATA(stack_wd), .VM_WR_DATA(vm_wd), .MODE_IRQ_STACK(mode_stack),
    .VM_STACK(vm_stack), .PC_LOAD(pc_load), .PC_VALUE(pc_value),
    .EXCEPTION_RETURN_PC(exception_return_pc), .STATE_IDX(state_idx), .STATE_RD_DATA(state_rd),
    .STATE_WR_EN(state_we), .STATE_WR_DATA(state_wd), .MEM_REQ(mem_req), .MEM_WE(mem_we),
    .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_READY(mem_ready),
    .MEM_RDATA(mem_rdata), .SEQ_BUSY(seq_busy), .IRQ_ANY(irq_any), .IRQ_TOP_LINE(irq_top));
  ecs_frame_model i_ecs_frame_model (
    .clk(ref_clk), .rst(rst), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .state_idx(state_idx), .state_rd_data(state_rd));

  always #20 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Inputs move one nanosecond after the edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // Old area of the class that owns a recorded code
  function automatic logic [31:0] old_area(input logic [4:0] c);
    if (c == 5'h00) return `ECS_INT_OLD;
    if (c <= 5'h03) return `ECS_TLB_OLD;
    if (c == 5'h08 || c == 5'h09) return `ECS_SVC_OLD;
    return `ECS_PGM_OLD;
  endfunction : old_area

  // Follows one taken exception through entry, save and restore
  task automatic serve(input logic [31:0] base, input logic [31:0] pc_exp,
                       input logic [31:0] vec, input logic [4:0] code);
    int n;
    int restored;
    n = 0;
    restored = 0;
    while (pc_load !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    check("vector", pc_value, vec);
    check("return pc", exception_return_pc, pc_exp);
    check("mode stack", 32'(mode_stack), 32'h0000_0034);
    check("vm stack", 32'(vm_stack), 32'h0000_0002);
    // A raise while busy must be ignored, the code stays
    exc_code = `ECS_CODE_BRK;
    exc_raise = 1'b1;
    tick(1);
    exc_raise = 1'b0;
    n = 0;
    while (seq_busy === 1'b1 && n < 2000) begin
      tick(1);
      n++;
      if (state_we === 1'b1) restored++;
      if (pc_load === 1'b1) check("restored pc", pc_value, ~(base + 32'h0000_0098));
      if (pc_load === 1'b1) check("restored word", state_wd, ~(base + 32'h0000_0098));
    end
    tick(1);
    check("restored words", restored, 32'd35);
    check("saved pc", i_ecs_frame_model.mem[base[11:2] + 10'd3], pc_exp);
    check("saved cause", 32'(i_ecs_frame_model.mem[base[11:2] + 10'd1][6:2]), 32'(code));
    check("saved word 34", i_ecs_frame_model.mem[base[11:2] + 10'd34], 32'h5A00_0022);
    check("code", 32'(cause_rd[6:2]), 32'(code));
  endtask : serve

  // Cut a hang short, far beyond the expected run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(3);
    rst = 1'b0;
    check("cause after reset", cause_rd, `ECS_CAUSE_RESET);
    // Several lines at once, then a change, show through live
    irq_lines = 8'hA4;
    tick(4);
    check("pending lines", 32'(cause_rd[15:8]), 32'h0000_00A4);
    check("top line", 32'(irq_top), 32'h0000_0002);
    check("any line", 32'(irq_any), 32'h0000_0001);
    irq_lines = 8'h18;
    tick(4);
    check("pending lines", 32'(cause_rd[15:8]), 32'h0000_0018);
    irq_lines = 8'h00;
    $display("test pending lines done");
    // Only software pending bits 0 and 1 take a write
    for (int k = 0; k < 2; k++) begin
      cause_wd = (k == 0) ? 32'hFFFF_FFFF : 32'h0000_0000;
      cause_we = 1'b1;
      tick(1);
      cause_we = 1'b0;
      tick(3);
      check("written cause", cause_rd, (k == 0) ? 32'h0000_0300 : 32'h0000_0000);
    end
    $display("test software pending done");
    // Every code, each with its own class, vector and answer speed
    for (int c = 0; c < 15; c++) begin
      stack_wd = 6'h0D;
      vm_wd = 3'b101;
      stack_we = 1'b1;
      tick(1);
      stack_we = 1'b0;
      slow = c[0];
      exc_code = c[4:0];
      exc_cpu = c[1:0];
      exc_dly = c[0];
      boot_sel = c[0];
      exc_pc = 32'h0040_0000 + 32'(c << 2);
      exc_raise = 1'b1;
      tick(1);
      exc_raise = 1'b0;
      if (c == 11) ce_exp = 2'b11;
      code_exp = (c > 12) ? `ECS_CODE_ILL : c[4:0];
      serve(old_area(code_exp), exc_pc, c[0] ? `ECS_VEC_BOOT : `ECS_VEC_EXEC, code_exp);
      check("cop index", 32'(cause_rd[29:28]), 32'(ce_exp));
      check("delay flag", 32'(cause_rd[31]), 32'(c[0]));
    end
    $display("test exception codes done");
    // A line interrupt taken once its enable is set
    stack_we = 1'b1;
    tick(1);
    stack_we = 1'b0;
    exc_pc = 32'h0040_1000;
    boot_sel = 1'b0;
    irq_lines = 8'h30;
    serve(`ECS_INT_OLD, 32'h0040_1000, `ECS_VEC_EXEC, `ECS_CODE_INT);
    check("irq pending", 32'(cause_rd[15:8]), 32'h0000_0030);
    irq_lines = 8'h00;
    // Return pops both stacks once the released lines have left the syncs
    tick(2);
    exc_ret = 1'b1;
    tick(1);
    exc_ret = 1'b0;
    check("popped stacks", 32'({vm_stack, mode_stack}), 32'h0000_007D);
    $display("test line interrupt done");
    final_report();
  end
endmodule : exception_cause_state_test

`default_nettype wire
